/* File: design/dlct_timers.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dlct_map.svh"
module dlct_timers (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire dlct_pkg::dlct_sfr_req_t i_sfr,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_hit,
  input wire logic i_first_count_pin,
  input wire logic i_second_count_pin,
  input wire logic i_first_gate_input,
  input wire logic i_second_gate_input,
  input wire logic i_ext_clock,
  input wire logic i_first_irq_ack,
  input wire logic i_second_irq_ack,
  input wire logic i_first_irq_enable,
  input wire logic i_second_irq_enable,
  output logic o_first_irq,
  output logic o_second_irq,
  output logic o_second_overflow_pulse,
  output logic o_timer3_high_clock_sel,
  output logic o_timer3_low_clock_sel,
  output logic o_timer2_high_clock_sel,
  output logic o_timer2_low_clock_sel
);
  import dlct_pkg::*;

  logic [7:0] timer_clock_control_r;
  logic [7:0] timer_mode_reg_r;
  logic [7:0] ext_irq_config_r;
  logic first_run_bit_r;
  logic second_run_bit_r;
  logic first_overflow_flag_r;
  logic second_overflow_flag_r;
  logic [7:0] first_count_low_r;
  logic [7:0] first_count_high_r;
  logic [7:0] second_count_low_r;
  logic [7:0] second_count_high_r;
  logic [7:0] first_low_nxt;
  logic [7:0] first_high_nxt;
  logic [7:0] second_low_nxt;
  logic [7:0] second_high_nxt;
  logic [7:0] rdata_nxt;
  logic first_ovf;
  logic split_high_ovf;
  logic second_ovf;
  logic [2:0] sync_level;
  logic [2:0] sync_fall;
  logic ext_fall;
  logic pre_tick;
  dlct_tcfg_t first_cfg;
  dlct_tcfg_t second_cfg;
  logic first_step;
  logic second_step;
  logic split_high_step;
  logic first_split;
  logic wr_run_flags;

  function automatic logic gate_open(input logic run, input logic gate_en,
                                     input logic level, input logic pol);
    gate_open = run && (!gate_en || (level == pol));
  endfunction : gate_open

  // Timer-function step: every clock or prescaler tick; counter: pin fall
  function automatic logic step_src(input logic counter_sel, input logic clk_sel,
                                    input logic tick, input logic pin_fall);
    if (counter_sel) step_src = pin_fall;
    else step_src = clk_sel ? 1'b1 : tick;
  endfunction : step_src

  function automatic logic [8:0] inc8(input logic [7:0] v);
    inc8 = {1'b0, v} + 9'h001;
  endfunction : inc8

  // Runs a full timer step; returns {ovf, high, low}
  function automatic logic [16:0] advance(input dlct_mode_t mode, input logic [7:0] lo,
                                          input logic [7:0] hi);
    logic [16:0] r;
    logic [12:0] c13;
    logic [16:0] c16;
    logic [8:0] n;
    r = {1'b0, hi, lo};
    n = inc8(lo);
    c13 = 13'h0000;
    c16 = 17'h00000;
    case (mode)
      DLCT_MODE_13BIT: begin
        c13 = {hi, lo[4:0]} + 13'h0001;
        r = {(c13 == 13'h0000), c13[12:5], lo[7:5], c13[4:0]};
      end
      DLCT_MODE_16BIT: begin
        c16 = {1'b0, hi, lo} + 17'h00001;
        r = c16;
      end
      DLCT_MODE_RELOAD8: begin
        if (lo == 8'hFF) r = {1'b1, hi, hi};
        else r = {1'b0, hi, n[7:0]};
      end
      default: begin
        r = {n[8], hi, n[7:0]};
      end
    endcase
    advance = r;
  endfunction : advance

  dlct_edge_sync #(
    .WIDTH(3)
  ) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_async({i_ext_clock, i_second_gate_input, i_first_gate_input}),
    .o_level(sync_level),
    .o_fall(sync_fall)
  );

  logic [1:0] pin_fall;
  dlct_edge_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_async({i_second_count_pin, i_first_count_pin}),
    .o_level(),
    .o_fall(pin_fall)
  );
  assign ext_fall = sync_fall[2];

  dlct_prescaler u_pre (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_prescale_code(timer_clock_control_r[1:0]),
    .i_ext_clk_fall(ext_fall),
    .o_tick(pre_tick)
  );

  assign first_cfg = dlct_tcfg_t'(timer_mode_reg_r[3:0]);
  assign second_cfg = dlct_tcfg_t'(timer_mode_reg_r[7:4]);
  assign first_split = (first_cfg.mode == DLCT_MODE_SPLIT);

  assign first_step = gate_open(first_run_bit_r, first_cfg.gate_en, sync_level[0],
                                ext_irq_config_r[`DLCT_GP_FIRST])
                      && step_src(first_cfg.counter_sel,
                                  timer_clock_control_r[`DLCT_CK_FIRST_SEL],
                                  pre_tick, pin_fall[0]);
  // Split high byte: timer function only, under the second run bit
  assign split_high_step = first_split && second_run_bit_r
                           && step_src(1'b0, timer_clock_control_r[`DLCT_CK_FIRST_SEL],
                                       pre_tick, 1'b0);

  always_comb begin
    if (second_cfg.mode == DLCT_MODE_SPLIT) second_step = 1'b0;
    else if (first_split)
      second_step = step_src(1'b0, timer_clock_control_r[`DLCT_CK_SECOND_SEL],
                             pre_tick, 1'b0);
    else
      second_step = gate_open(second_run_bit_r, second_cfg.gate_en, sync_level[1],
                              ext_irq_config_r[`DLCT_GP_SECOND])
                    && step_src(second_cfg.counter_sel,
                                timer_clock_control_r[`DLCT_CK_SECOND_SEL],
                                pre_tick, pin_fall[1]);
  end

  assign wr_run_flags = i_sfr.wr && (i_sfr.addr == `DLCT_ADDR_RUN_FLAGS);

  always_comb begin
    logic [16:0] a;
    logic [8:0] h;
    a = advance(first_cfg.mode, first_count_low_r, first_count_high_r);
    h = inc8(first_count_high_r);
    first_low_nxt = first_count_low_r;
    first_high_nxt = first_count_high_r;
    first_ovf = 1'b0;
    split_high_ovf = 1'b0;
    if (first_step) begin
      first_low_nxt = a[7:0];
      if (!first_split) first_high_nxt = a[15:8];
      first_ovf = a[16];
    end
    if (split_high_step) begin
      first_high_nxt = h[7:0];
      split_high_ovf = h[8];
    end
    // Software write lands after counting: the written value wins
    if (i_sfr.wr && i_sfr.addr == `DLCT_ADDR_FIRST_LOW) first_low_nxt = i_sfr.wdata;
    if (i_sfr.wr && i_sfr.addr == `DLCT_ADDR_FIRST_HIGH) first_high_nxt = i_sfr.wdata;
  end

  always_comb begin
    logic [16:0] a;
    a = advance(second_cfg.mode, second_count_low_r, second_count_high_r);
    second_low_nxt = second_count_low_r;
    second_high_nxt = second_count_high_r;
    second_ovf = 1'b0;
    if (second_step) begin
      second_low_nxt = a[7:0];
      second_high_nxt = a[15:8];
      second_ovf = a[16];
    end
    if (i_sfr.wr && i_sfr.addr == `DLCT_ADDR_SECOND_LOW) second_low_nxt = i_sfr.wdata;
    if (i_sfr.wr && i_sfr.addr == `DLCT_ADDR_SECOND_HIGH) second_high_nxt = i_sfr.wdata;
  end

  // Counts only change by counting or by direct writes, never by run
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      first_count_low_r <= `DLCT_RESET_BYTE;
      first_count_high_r <= `DLCT_RESET_BYTE;
      second_count_low_r <= `DLCT_RESET_BYTE;
      second_count_high_r <= `DLCT_RESET_BYTE;
    end else begin
      first_count_low_r <= first_low_nxt;
      first_count_high_r <= first_high_nxt;
      second_count_low_r <= second_low_nxt;
      second_count_high_r <= second_high_nxt;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      timer_clock_control_r <= `DLCT_RESET_BYTE;
      timer_mode_reg_r <= `DLCT_RESET_BYTE;
      ext_irq_config_r <= `DLCT_RESET_BYTE;
    end else if (i_sfr.wr) begin
      case (i_sfr.addr)
        `DLCT_ADDR_CLOCK_CTRL: timer_clock_control_r <= i_sfr.wdata;
        `DLCT_ADDR_MODE: timer_mode_reg_r <= i_sfr.wdata;
        `DLCT_ADDR_GATE_POL: ext_irq_config_r <= i_sfr.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      first_run_bit_r <= 1'b0;
      second_run_bit_r <= 1'b0;
    end else if (wr_run_flags) begin
      first_run_bit_r <= i_sfr.wdata[`DLCT_RF_FIRST_RUN];
      second_run_bit_r <= i_sfr.wdata[`DLCT_RF_SECOND_RUN];
    end
  end

  // Hardware set wins over software clear and vector acknowledge
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      first_overflow_flag_r <= 1'b0;
      second_overflow_flag_r <= 1'b0;
    end else begin
      if (first_ovf) first_overflow_flag_r <= 1'b1;
      else if (i_first_irq_ack) first_overflow_flag_r <= 1'b0;
      else if (wr_run_flags) first_overflow_flag_r <= i_sfr.wdata[`DLCT_RF_FIRST_FLAG];
      if (split_high_ovf || (second_ovf && !first_split)) second_overflow_flag_r <= 1'b1;
      else if (i_second_irq_ack) second_overflow_flag_r <= 1'b0;
      else if (wr_run_flags) second_overflow_flag_r <= i_sfr.wdata[`DLCT_RF_SECOND_FLAG];
    end
  end

  always_comb begin
    rdata_nxt = 8'h00;
    case (i_sfr.addr)
      `DLCT_ADDR_RUN_FLAGS: rdata_nxt = {second_overflow_flag_r, second_run_bit_r,
                                         first_overflow_flag_r, first_run_bit_r, 4'h0};
      `DLCT_ADDR_MODE: rdata_nxt = timer_mode_reg_r;
      `DLCT_ADDR_FIRST_LOW: rdata_nxt = first_count_low_r;
      `DLCT_ADDR_SECOND_LOW: rdata_nxt = second_count_low_r;
      `DLCT_ADDR_FIRST_HIGH: rdata_nxt = first_count_high_r;
      `DLCT_ADDR_SECOND_HIGH: rdata_nxt = second_count_high_r;
      `DLCT_ADDR_CLOCK_CTRL: rdata_nxt = timer_clock_control_r;
      `DLCT_ADDR_GATE_POL: rdata_nxt = ext_irq_config_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Read data registered: valid the cycle after the read strobe
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_sfr_rdata <= 8'h00;
      o_sfr_hit <= 1'b0;
      o_second_overflow_pulse <= 1'b0;
    end else begin
      o_sfr_rdata <= i_sfr.rd ? rdata_nxt : 8'h00;
      // Only decoded addresses answer; the rest of the page stays silent
      o_sfr_hit <= i_sfr.rd && ((i_sfr.addr >= `DLCT_ADDR_RUN_FLAGS
                                 && i_sfr.addr <= `DLCT_ADDR_CLOCK_CTRL)
                                || i_sfr.addr == `DLCT_ADDR_GATE_POL);
      o_second_overflow_pulse <= second_ovf;
    end
  end

  assign o_first_irq = first_overflow_flag_r && i_first_irq_enable;
  assign o_second_irq = second_overflow_flag_r && i_second_irq_enable;
  assign o_timer3_high_clock_sel = timer_clock_control_r[7];
  assign o_timer3_low_clock_sel = timer_clock_control_r[6];
  assign o_timer2_high_clock_sel = timer_clock_control_r[5];
  assign o_timer2_low_clock_sel = timer_clock_control_r[4];
  // Software must preload the high byte, the reload value, before enabling reload mode
endmodule : dlct_timers
`default_nettype wire

/* File: design/dlct_map.svh */
`ifndef DLCT_MAP_SVH
`define DLCT_MAP_SVH
// Register addresses on the special-function register port
`define DLCT_ADDR_RUN_FLAGS 8'h88
`define DLCT_ADDR_MODE 8'h89
`define DLCT_ADDR_FIRST_LOW 8'h8A
`define DLCT_ADDR_SECOND_LOW 8'h8B
`define DLCT_ADDR_FIRST_HIGH 8'h8C
`define DLCT_ADDR_SECOND_HIGH 8'h8D
`define DLCT_ADDR_CLOCK_CTRL 8'h8E
`define DLCT_ADDR_GATE_POL 8'hE4
// Run/flag register fields
`define DLCT_RF_SECOND_FLAG 7
`define DLCT_RF_SECOND_RUN 6
`define DLCT_RF_FIRST_FLAG 5
`define DLCT_RF_FIRST_RUN 4
// Mode register fields (second timer in the upper nibble)
`define DLCT_MD_GATE 3
`define DLCT_MD_CSEL 2
// Clock control fields
`define DLCT_CK_SECOND_SEL 3
`define DLCT_CK_FIRST_SEL 2
// Gate polarity bits in the external interrupt configuration register
`define DLCT_GP_FIRST 3
`define DLCT_GP_SECOND 7
`define DLCT_RESET_BYTE 8'h00
// Prescale divisors
`define DLCT_DIV_12 12
`define DLCT_DIV_4 4
`define DLCT_DIV_48 48
`define DLCT_DIV_EXT 8
`endif

/* File: design/dlct_pkg.sv */
package dlct_pkg;
  typedef enum logic [1:0] {
    DLCT_MODE_13BIT,
    DLCT_MODE_16BIT,
    DLCT_MODE_RELOAD8,
    DLCT_MODE_SPLIT
  } dlct_mode_t;

  typedef struct packed {
    logic gate_en;
    logic counter_sel;
    dlct_mode_t mode;
  } dlct_tcfg_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dlct_sfr_req_t;
endpackage : dlct_pkg

/* File: design/dlct_edge_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module dlct_edge_sync #(
  parameter int WIDTH = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_level,
  output logic [WIDTH-1:0] o_fall
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] prev_r;

  initial begin
    if (WIDTH < 1) $error("dlct_edge_sync: WIDTH must be positive");
  end

  // First stage feeds only the second stage
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign o_level = sync_r;
  assign o_fall = prev_r & ~sync_r;
endmodule : dlct_edge_sync
`default_nettype wire

/* File: design/dlct_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dlct_map.svh"
module dlct_prescaler (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic [1:0] i_prescale_code,
  input wire logic i_ext_clk_fall,
  output logic o_tick
);
  import dlct_pkg::*;
  logic [5:0] cnt_r;
  logic [5:0] limit;
  logic step;

  always_comb begin
    case (i_prescale_code)
      2'b00: limit = 6'(`DLCT_DIV_12 - 1);
      2'b01: limit = 6'(`DLCT_DIV_4 - 1);
      2'b10: limit = 6'(`DLCT_DIV_48 - 1);
      default: limit = 6'(`DLCT_DIV_EXT - 1);
    endcase
  end

  // External clock only advances on its synchronised falling edges
  assign step = (i_prescale_code == 2'b11) ? i_ext_clk_fall : 1'b1;

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_r <= '0;
    end else if (step) begin
      cnt_r <= (cnt_r >= limit) ? 6'h00 : cnt_r + 6'h01;
    end
  end

  assign o_tick = step && (cnt_r >= limit);
endmodule : dlct_prescaler
`default_nettype wire

/* File: test/dlct_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dlct_pin_model (
  input wire logic i_clk_sys,
  input wire logic i_fire,
  output logic o_pin
);
  int hold = 0;
  // Low for three clocks, then high for four: each level lasts two clocks or more
  always @(negedge i_clk_sys) begin
    if (i_fire && hold == 0) begin
      hold <= 7;
    end else if (hold > 0) begin
      hold <= hold - 1;
    end
  end
  // Idle level is high, as with a pulled-up pin
  assign o_pin = !(hold > 4);
endmodule : dlct_pin_model
`default_nettype wire

/* File: test/dlct_timers_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dlct_map.svh"
module dlct_timers_monitor (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire dlct_pkg::dlct_sfr_req_t i_sfr,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic o_sfr_hit,
  input wire logic i_first_irq_enable,
  input wire logic i_second_irq_enable,
  input wire logic o_first_irq,
  input wire logic o_second_irq,
  input wire logic o_timer3_high_clock_sel,
  input wire logic o_timer3_low_clock_sel,
  input wire logic o_timer2_high_clock_sel,
  input wire logic o_timer2_low_clock_sel
);
  import dlct_pkg::*;
  logic [3:0] sel;
  logic mapped;
  logic ck_wr;
  assign sel = {o_timer3_high_clock_sel, o_timer3_low_clock_sel,
    o_timer2_high_clock_sel, o_timer2_low_clock_sel};
  assign mapped = i_sfr.addr inside {[`DLCT_ADDR_RUN_FLAGS:`DLCT_ADDR_CLOCK_CTRL],
    `DLCT_ADDR_GATE_POL};
  assign ck_wr = i_sfr.wr && i_sfr.addr == `DLCT_ADDR_CLOCK_CTRL;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_reset_n);
  a_unmapped_read_quiet: assert property (
    i_sfr.rd && !mapped |=> !o_sfr_hit && o_sfr_rdata == 8'h00) else $error("unmapped read");
  a_mapped_read_hit: assert property (
    i_sfr.rd && mapped |=> o_sfr_hit) else $error("mapped read without hit");
  a_idle_bus_quiet: assert property (
    !i_sfr.rd |=> !o_sfr_hit && o_sfr_rdata == 8'h00) else $error("read data without read");
  a_clksel_load: assert property (
    ck_wr |=> sel == $past(i_sfr.wdata[7:4])) else $error("clock selects not loaded");
  a_clksel_hold: assert property (
    !ck_wr |=> $stable(sel)) else $error("clock selects moved");
  a_clksel_readback: assert property (
    i_sfr.rd && !i_sfr.wr && i_sfr.addr == `DLCT_ADDR_CLOCK_CTRL |=> o_sfr_rdata[7:4] == sel)
    else $error("clock control read mismatch");
  a_first_irq_masked: assert property (
    !i_first_irq_enable |-> !o_first_irq) else $error("first irq while disabled");
  a_second_irq_masked: assert property (
    !i_second_irq_enable |-> !o_second_irq) else $error("second irq while disabled");
  c_read_hit: cover property (i_sfr.rd && mapped ##1 o_sfr_hit);
  c_first_irq: cover property ($rose(o_first_irq));
  c_second_irq: cover property ($rose(o_second_irq));
endmodule : dlct_timers_monitor
bind dlct_timers dlct_timers_monitor i_dlct_timers_monitor (
  .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_sfr(i_sfr),
  .o_sfr_rdata(o_sfr_rdata), .o_sfr_hit(o_sfr_hit),
  .i_first_irq_enable(i_first_irq_enable), .i_second_irq_enable(i_second_irq_enable),
  .o_first_irq(o_first_irq), .o_second_irq(o_second_irq),
  .o_timer3_high_clock_sel(o_timer3_high_clock_sel),
  .o_timer3_low_clock_sel(o_timer3_low_clock_sel),
  .o_timer2_high_clock_sel(o_timer2_high_clock_sel),
  .o_timer2_low_clock_sel(o_timer2_low_clock_sel)
);
`default_nettype wire

/* File: test/dlct_timers_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dlct_map.svh"
module dlct_timers_bench;
  import dlct_pkg::*;
  localparam logic [7:0] ad_run = `DLCT_ADDR_RUN_FLAGS;
  localparam logic [7:0] ad_mode = `DLCT_ADDR_MODE;
  localparam logic [7:0] ad_lo0 = `DLCT_ADDR_FIRST_LOW;
  localparam logic [7:0] ad_lo1 = `DLCT_ADDR_SECOND_LOW;
  localparam logic [7:0] ad_hi0 = `DLCT_ADDR_FIRST_HIGH;
  localparam logic [7:0] ad_hi1 = `DLCT_ADDR_SECOND_HIGH;
  localparam logic [7:0] ad_ck = `DLCT_ADDR_CLOCK_CTRL;
  localparam logic [7:0] ad_pol = `DLCT_ADDR_GATE_POL;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  dlct_sfr_req_t sfr = '0;
  logic [7:0] rdata;
  logic hit;
  logic ext_clk = 1'b0;
  logic [1:0] gate = 2'b00;
  logic [1:0] fire = 2'b00;
  logic [1:0] irq_en = 2'b00;
  logic [1:0] ack = 2'b00;
  logic [1:0] pin;
  logic [1:0] irq;
  logic [3:0] sel;
  logic ovf_pulse;
  int pulses = 0;
  int n_fail = 0;
  int comparisons = 0;
  int ext_cnt = 0;
  initial begin
    forever #20 clk = ~clk;
  end
  // External clock falls every 8 system clocks
  always @(negedge clk) begin
    ext_cnt <= ext_cnt + 1;
    ext_clk <= ext_cnt[2];
  end
  // Counted mid-cycle, where the one-cycle pulse has settled
  always @(negedge clk) begin
    if (ovf_pulse) pulses <= pulses + 1;
  end
  dlct_timers i_dlct_timers (
    .i_clk_sys(clk), .i_reset_n(rst_n), .i_sfr(sfr), .o_sfr_rdata(rdata), .o_sfr_hit(hit),
    .i_first_count_pin(pin[0]), .i_second_count_pin(pin[1]),
    .i_first_gate_input(gate[0]), .i_second_gate_input(gate[1]), .i_ext_clock(ext_clk),
    .i_first_irq_ack(ack[0]), .i_second_irq_ack(ack[1]),
    .i_first_irq_enable(irq_en[0]), .i_second_irq_enable(irq_en[1]),
    .o_first_irq(irq[0]), .o_second_irq(irq[1]), .o_second_overflow_pulse(ovf_pulse),
    .o_timer3_high_clock_sel(sel[3]), .o_timer3_low_clock_sel(sel[2]),
    .o_timer2_high_clock_sel(sel[1]), .o_timer2_low_clock_sel(sel[0])
  );
  dlct_pin_model i_dlct_pin_model (.i_clk_sys(clk), .i_fire(fire[0]), .o_pin(pin[0]));
  dlct_pin_model i_dlct_pin_model_b (.i_clk_sys(clk), .i_fire(fire[1]), .o_pin(pin[1]));
  task automatic finish_test;
    $display("Comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    sfr.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    sfr <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    d = rdata;
    sfr.rd <= 1'b0;
  endtask : rd
  task automatic rdchk(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk(n, e, v);
  endtask : rdchk
  // Any window of w clocks, w a multiple of the period, holds exactly w / period steps, whatever the phase
  task automatic meas(input logic [7:0] a, input int w, input logic [7:0] e);
    logic [7:0] v0;
    logic [7:0] v1;
    rd(a, v0);
    repeat (w - 2) @(negedge clk);
    rd(a, v1);
    chk("step count", e, v1 - v0);
  endtask : meas
  task automatic pulse(input int t, input int n);
    repeat (n) begin
      @(negedge clk);
      fire[t] <= 1'b1;
      @(negedge clk);
      fire[t] <= 1'b0;
      repeat (9) @(negedge clk);
    end
  endtask : pulse
  task automatic t_regs;
    rdchk("clock ctrl reset", ad_ck, 8'h00);
    rdchk("unmapped", 8'h80, 8'h00);
    chk("unmapped hit", 8'h00, {7'h0, hit});
    wr(ad_ck, 8'hA3);
    chk("alt clock selects", 8'h0A, {4'h0, sel});
    rdchk("clock ctrl", ad_ck, 8'hA3);
    chk("mapped hit", 8'h01, {7'h0, hit});
    $display("Test registers done");
  endtask : t_regs
  task automatic t_prescale;
    int div [4] = '{12, 4, 48, 64};
    wr(ad_mode, 8'h11);
    wr(ad_run, 8'h50);
    for (int c = 0; c < 4; c++) begin
      wr(ad_ck, 8'(c));
      // Settle so a code change mid-count cannot skew the window
      repeat (128) @(negedge clk);
      meas(ad_lo0, 3 * div[c], 8'h03);
      meas(ad_lo1, 3 * div[c], 8'h03);
    end
    wr(ad_ck, 8'h04);
    meas(ad_lo0, 3, 8'h03);
    meas(ad_lo1, 36, 8'h03);
    wr(ad_ck, 8'h08);
    meas(ad_lo1, 3, 8'h03);
    $display("Test prescaler done");
  endtask : t_prescale
  task automatic t_overflow;
    wr(ad_ck, 8'h04);
    for (int m = 0; m < 2; m++) begin
      wr(ad_run, 8'h00);
      wr(ad_mode, 8'(m));
      wr(ad_hi0, 8'hFF);
      wr(ad_lo0, 8'hFE);
      wr(ad_run, 8'h10);
      repeat (4) @(negedge clk);
      rdchk("wrap high", ad_hi0, 8'h00);
      rdchk("wrap flag", ad_run, 8'h30);
      chk("masked irq", 8'h00, {7'h0, irq[0]});
      irq_en[0] <= 1'b1;
      @(negedge clk);
      chk("irq", 8'h01, {7'h0, irq[0]});
      if (m == 0) begin
        ack[0] <= 1'b1;
        @(negedge clk);
        ack[0] <= 1'b0;
      end else begin
        wr(ad_run, 8'h10);
      end
      rdchk("flag cleared", ad_run, 8'h10);
      irq_en[0] <= 1'b0;
    end
    $display("Test overflow done");
  endtask : t_overflow
  task automatic t_reload;
    wr(ad_run, 8'h00);
    wr(ad_mode, 8'h02);
    wr(ad_hi0, 8'hA0);
    wr(ad_lo0, 8'hFE);
    wr(ad_run, 8'h10);
    repeat (6) @(negedge clk);
    rdchk("reload high", ad_hi0, 8'hA0);
    // Nine steps by the read: FE, FF, reload to A0, then up to A7
    rdchk("reload low", ad_lo0, 8'hA7);
    rdchk("reload flag", ad_run, 8'h30);
    wr(ad_run, 8'h00);
    $display("Test reload done");
  endtask : t_reload
  task automatic t_counter(input int t);
    logic [7:0] lo;
    lo = ad_lo0 + 8'(t);
    wr(ad_run, 8'h00);
    wr(ad_mode, 8'(8'h0D << (4 * t)));
    wr(lo, 8'h00);
    wr(ad_pol, 8'(8'h08 << (4 * t)));
    gate[t] <= 1'b0;
    wr(ad_run, 8'(8'h10 << (2 * t)));
    pulse(t, 2);
    rdchk("gated off", lo, 8'h00);
    gate[t] <= 1'b1;
    pulse(t, 3);
    rdchk("pin count", lo, 8'h03);
    wr(ad_pol, 8'h00);
    pulse(t, 1);
    rdchk("polarity low", lo, 8'h03);
    gate[t] <= 1'b0;
    $display("Test counter %0d done", t);
  endtask : t_counter
  task automatic t_split;
    int p0;
    wr(ad_run, 8'h00);
    wr(ad_ck, 8'h0C);
    wr(ad_mode, 8'h13);
    wr(ad_lo0, 8'h55);
    wr(ad_hi0, 8'hFE);
    irq_en[1] <= 1'b1;
    wr(ad_run, 8'h40);
    repeat (4) @(negedge clk);
    rdchk("split low idle", ad_lo0, 8'h55);
    rdchk("split flags", ad_run, 8'hC0);
    chk("split irq", 8'h01, {7'h0, irq[1]});
    ack[1] <= 1'b1;
    @(negedge clk);
    ack[1] <= 1'b0;
    rdchk("second flag acked", ad_run, 8'h40);
    wr(ad_run, 8'h00);
    // Second timer wraps inside the window: pulse only, no flag
    wr(ad_hi1, 8'hFF);
    p0 = pulses;
    wr(ad_lo1, 8'hFC);
    meas(ad_lo1, 3, 8'h03);
    chk("overflow pulse", 8'h01, 8'(pulses - p0));
    wr(ad_mode, 8'h33);
    meas(ad_lo1, 9, 8'h00);
    rdchk("no second flag", ad_run, 8'h00);
    $display("Test split done");
  endtask : t_split
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_prescale();
    t_overflow();
    t_reload();
    t_counter(0);
    t_counter(1);
    t_split();
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("Error watchdog expected end seen hang");
    finish_test();
  end
endmodule : dlct_timers_bench
`default_nettype wire
